/* File: design/srp_packetizer.sv */
// Serial front end: idle and escape packetizer, command mode and host framer.
`timescale 1ns/100ps

// ------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------
module srp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	wire do_push = in_valid && in_ready;
	wire do_pop = out_valid && out_ready;

	assign in_ready = level != ($clog2(DEPTH+1))'(DEPTH);
	assign out_valid = level != '0;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				level <= level + 1'b1;
			end else if (do_pop && !do_push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule

// ------------------------------------------------------------
// Top
// ------------------------------------------------------------
// Summary of operation
// - Transparent: queue serial bytes unless commanding
// - Transparent: radio payload goes out to host
// - No transparent operation on SPI port
// - Transparent: configure only in command mode
// - Idle count zero packetizes at once
// - Packetize after idle count character times
// - Idle wait never below 100 microseconds
// - Escape pattern: flush buffer, then command mode
// - Full packet worth of bytes sends immediately
// - Framed operation: all traffic inside frames
// - Device emits data, response, event frames
// - Transmit status frame may follow transmission
// - Received data frames carry source address
// - SPI port always uses framed operation
// - Default escape three plus, guard 0x3E8
// - Default idle count is three characters
module srp_packetizer import srp_pkg::*; #(
	parameter int GUARD_TICK_CYCLES = GUARD_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic din_pin,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic spi_port_select,
	input wire logic framed_mode_select,
	input wire logic cfg_load,
	input wire srp_cfg_s cfg_in,
	input wire logic cmd_exit,
	output srp_cfg_s cfg_active,
	output logic serial_rx_ready,
	output logic command_mode,
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	output logic frame_in_valid,
	output logic [7:0] frame_in_data,
	output logic tx_valid,
	output srp_byte_s tx_byte,
	input wire logic tx_ready,
	input wire logic rf_valid,
	input wire srp_byte_s rf_byte,
	input wire logic [15:0] rf_src_addr,
	output logic rf_ack,
	input wire logic ev_valid,
	input wire logic [7:0] ev_type,
	input wire logic [7:0] ev_code,
	output logic ev_ack,
	output logic host_valid,
	output srp_byte_s host_byte,
	input wire logic host_ready
);
	localparam int TW = $clog2(GUARD_TICK_CYCLES + 1);
	localparam int LW = $clog2(FIFO_DEPTH + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(GUARD_TICK_CYCLES - 1);
	localparam logic [IDLE_W-1:0] MIN_IDLE = IDLE_W'(MIN_IDLE_CYCLES);
	localparam logic [LW-1:0] PKT_MAX = LW'(PKT_MAX_BYTES);
	localparam logic [LW-1:0] ONE_LEFT = LW'(1);
	localparam logic [5:0] SENT_LAST = 6'(PKT_MAX_BYTES - 1);
	localparam logic [1:0] ESC_LAST = 2'(ESC_COUNT - 1);

	srp_cfg_s cfg;
	srp_esc_e esc_state;
	srp_esc_e next_esc_state;
	srp_host_e host_state;
	logic din_meta;
	logic din_sync;
	logic din_prev;
	logic [IDLE_W-1:0] idle_cnt;
	logic [IDLE_W-1:0] idle_thresh;
	logic [TW-1:0] tick_cnt;
	logic [GUARD_W-1:0] silence;
	logic [1:0] esc_pend;
	logic held_valid;
	logic [7:0] held_data;
	logic push_valid;
	logic [7:0] push_data;
	logic pkt_busy;
	logic [5:0] sent_cnt;
	logic [7:0] code_hold;
	logic [ADDR_W-1:0] addr_hold;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out;
	logic [LW-1:0] fifo_level;
	logic fifo_pop;

	// ------------------------------------------------------------
	// Mode and configuration
	// ------------------------------------------------------------
	wire framed = framed_mode_select || spi_port_select;
	wire cfg_allowed = framed || esc_state == ESC_CMD;
	wire [CHAR_W-1:0] char_cycles = cfg.bit_period * cfg.frame_bits;
	wire [IDLE_W-1:0] ro_cycles = cfg.idle_packetize_chars * char_cycles;
	wire [IDLE_W-1:0] ro_floor = (ro_cycles < MIN_IDLE) ? MIN_IDLE : ro_cycles;

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg <= '{DEF_IDLE_CHARS, DEF_GUARD, DEF_ESC_CHAR, DEF_BIT_PERIOD,
				DEF_FRAME_BITS};
			idle_thresh <= MIN_IDLE;
		end else begin
			if (cfg_load && cfg_allowed) begin
				cfg <= cfg_in;
			end
			idle_thresh <= ro_floor;
		end
	end

	// ------------------------------------------------------------
	// Line idle and guard silence timers
	// ------------------------------------------------------------
	wire din_edge = din_sync != din_prev;
	wire tick = tick_cnt == TICK_LAST;
	wire idle_done = idle_cnt >= idle_thresh;
	wire guard_met = silence >= cfg.silence_guard_time;

	always_ff @(posedge clk) begin
		if (reset) begin
			din_meta <= 1'b1;
			din_sync <= 1'b1;
			din_prev <= 1'b1;
			idle_cnt <= '0;
			tick_cnt <= '0;
			silence <= '0;
		end else begin
			din_meta <= din_pin;
			din_sync <= din_meta;
			din_prev <= din_sync;
			if (din_edge) begin
				idle_cnt <= '0;
			end else if (!idle_done) begin
				idle_cnt <= idle_cnt + 1'b1;
			end
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			if (rx_valid) begin
				silence <= '0;
			end else if (tick && !(&silence)) begin
				silence <= silence + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Escape sequence detector and FIFO feed
	// ------------------------------------------------------------
	// Candidate escape characters are held back, not queued, so that a
	// completed pattern never leaks into a radio packet. On an abort the
	// held characters are replayed first; a byte arriving during replay
	// cannot happen because replay is far shorter than one character.
	wire rx_is_esc = rx_valid && rx_data == cfg.escape_sequence_char;
	wire esc_within = rx_is_esc && !guard_met;
	wire pkt_idle = !pkt_busy && !tx_valid;

	always_comb begin
		next_esc_state = esc_state;
		push_valid = 1'b0;
		push_data = rx_data;
		case (esc_state)
			ESC_IDLE: begin
				if (rx_is_esc && guard_met) begin
					next_esc_state = ESC_CHARS;
				end else if (rx_valid) begin
					push_valid = 1'b1;
				end
			end
			ESC_CHARS: begin
				if (esc_within && esc_pend == ESC_LAST) begin
					next_esc_state = ESC_POST;
				end else if ((rx_valid && !esc_within) || (!rx_valid && guard_met)) begin
					next_esc_state = ESC_FLUSH;
				end
			end
			ESC_POST: begin
				if (rx_valid) begin
					next_esc_state = ESC_FLUSH;
				end else if (guard_met) begin
					next_esc_state = ESC_DRAIN;
				end
			end
			ESC_FLUSH: begin
				if (esc_pend != '0) begin
					push_valid = 1'b1;
					push_data = cfg.escape_sequence_char;
				end else if (held_valid) begin
					push_valid = 1'b1;
					push_data = held_data;
				end else begin
					next_esc_state = ESC_IDLE;
				end
			end
			ESC_DRAIN: begin
				if (pkt_idle && !fifo_out_valid) begin
					next_esc_state = ESC_CMD;
				end
			end
			ESC_CMD: begin
				if (cmd_exit) begin
					next_esc_state = ESC_IDLE;
				end
			end
			default: begin
				next_esc_state = ESC_IDLE;
			end
		endcase
	end

	wire fifo_push = push_valid && !framed;
	wire push_done = fifo_push && fifo_in_ready;
	wire esc_step = esc_state == ESC_CHARS && esc_within;
	wire hold_now = rx_valid && next_esc_state == ESC_FLUSH && esc_state != ESC_FLUSH;
	wire replay_esc = esc_state == ESC_FLUSH && esc_pend != '0 && push_done;
	wire replay_held = esc_state == ESC_FLUSH && esc_pend == '0 && push_done;

	always_ff @(posedge clk) begin
		if (reset) begin
			esc_state <= ESC_IDLE;
			esc_pend <= '0;
			held_valid <= 1'b0;
			held_data <= '0;
		end else begin
			esc_state <= framed ? ESC_IDLE : next_esc_state;
			if (framed) begin
				esc_pend <= '0;
			end else if (esc_state == ESC_IDLE && next_esc_state == ESC_CHARS) begin
				esc_pend <= 2'd1;
			end else if (esc_step) begin
				esc_pend <= esc_pend + 1'b1;
			end else if (replay_esc || next_esc_state == ESC_DRAIN) begin
				esc_pend <= (esc_pend == '0) ? '0 : esc_pend - 1'b1;
			end
			if (framed || replay_held) begin
				held_valid <= 1'b0;
			end else if (hold_now) begin
				held_valid <= !(esc_state == ESC_CHARS && !rx_valid);
				held_data <= rx_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Byte routing toward command parser and frame parser
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			command_mode <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_data <= '0;
			frame_in_valid <= 1'b0;
			frame_in_data <= '0;
			serial_rx_ready <= 1'b0;
			cfg_active <= '0;
		end else begin
			command_mode <= !framed && next_esc_state == ESC_CMD;
			cmd_valid <= rx_valid && !framed && esc_state == ESC_CMD;
			cmd_data <= rx_data;
			frame_in_valid <= rx_valid && framed;
			frame_in_data <= rx_data;
			serial_rx_ready <= fifo_in_ready;
			cfg_active <= cfg;
		end
	end

	srp_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(fifo_push),
		.in_data(push_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out),
		.out_ready(fifo_pop),
		.level(fifo_level)
	);

	// ------------------------------------------------------------
	// Radio packetizer
	// ------------------------------------------------------------
	wire ro_zero = cfg.idle_packetize_chars == '0;
	wire pkt_full = fifo_level >= PKT_MAX;
	wire flush_req = esc_state == ESC_DRAIN;
	wire pkt_trigger = ro_zero || idle_done || flush_req || pkt_full;
	wire pkt_start = !pkt_busy && fifo_out_valid && pkt_trigger;
	wire tx_free = !tx_valid || tx_ready;
	assign fifo_pop = pkt_busy && fifo_out_valid && tx_free;
	wire pop_last = fifo_level == ONE_LEFT || sent_cnt == SENT_LAST;

	always_ff @(posedge clk) begin
		if (reset) begin
			pkt_busy <= 1'b0;
			sent_cnt <= '0;
			tx_valid <= 1'b0;
			tx_byte <= '0;
		end else begin
			if (pkt_start) begin
				pkt_busy <= 1'b1;
				sent_cnt <= '0;
			end else if (fifo_pop) begin
				pkt_busy <= !pop_last;
				sent_cnt <= sent_cnt + 1'b1;
			end
			if (fifo_pop) begin
				tx_valid <= 1'b1;
				tx_byte <= '{fifo_out, pop_last};
			end else if (tx_ready) begin
				tx_valid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Host output framer
	// ------------------------------------------------------------
	// Acknowledges are registered, so a request is never taken in the
	// cycle its acknowledge is high; the source advances meanwhile.
	wire host_free = !host_valid || host_ready;
	wire ev_take = framed && ev_valid && !ev_ack && host_free;
	wire rf_take = rf_valid && !rf_ack && host_free;

	always_ff @(posedge clk) begin
		if (reset) begin
			host_state <= H_IDLE;
			host_valid <= 1'b0;
			host_byte <= '0;
			rf_ack <= 1'b0;
			ev_ack <= 1'b0;
			code_hold <= '0;
			addr_hold <= '0;
		end else begin
			rf_ack <= 1'b0;
			ev_ack <= 1'b0;
			if (host_ready) begin
				host_valid <= 1'b0;
			end
			case (host_state)
				H_IDLE: begin
					if (ev_take) begin
						host_valid <= 1'b1;
						host_byte <= '{ev_type, 1'b0};
						code_hold <= ev_code;
						ev_ack <= 1'b1;
						host_state <= H_CODE;
					end else if (rf_take && framed) begin
						host_valid <= 1'b1;
						host_byte <= '{FT_RX_DATA, 1'b0};
						addr_hold <= rf_src_addr;
						host_state <= H_ADDR_HI;
					end else if (rf_take) begin
						host_state <= H_PAYLOAD;
					end
				end
				H_CODE: begin
					if (host_free) begin
						host_valid <= 1'b1;
						host_byte <= '{code_hold, 1'b1};
						host_state <= H_IDLE;
					end
				end
				H_ADDR_HI: begin
					if (host_free) begin
						host_valid <= 1'b1;
						host_byte <= '{addr_hold[15:8], 1'b0};
						host_state <= H_ADDR_LO;
					end
				end
				H_ADDR_LO: begin
					if (host_free) begin
						host_valid <= 1'b1;
						host_byte <= '{addr_hold[7:0], 1'b0};
						host_state <= H_PAYLOAD;
					end
				end
				H_PAYLOAD: begin
					if (rf_take) begin
						host_valid <= 1'b1;
						host_byte <= rf_byte;
						rf_ack <= 1'b1;
						host_state <= rf_byte.last ? H_IDLE : H_PAYLOAD;
					end
				end
				default: begin
					host_state <= H_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: design/srp_pkg.sv */
// Shared constants, types and defaults of the serial RF packetizer.
package srp_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int MIN_IDLE_US = 100;
	localparam int MIN_IDLE_CYCLES = ((CLK_HZ + 999_999) / 1_000_000) * MIN_IDLE_US;
	localparam int GUARD_UNIT_MS = 1;
	localparam int GUARD_UNIT_CYCLES = (CLK_HZ / 1000) * GUARD_UNIT_MS;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int PKT_MAX_BYTES = 32;
	localparam int ESC_COUNT = 3;
	localparam int IDLE_W = 28;
	localparam int CHAR_W = 20;
	localparam int GUARD_W = 16;
	localparam int ADDR_W = 16;
	// ------------------------------------------------------------
	// Configuration defaults
	// ------------------------------------------------------------
	localparam logic [7:0] DEF_IDLE_CHARS = 8'h03;
	localparam logic [15:0] DEF_GUARD = 16'h03E8;
	localparam logic [7:0] DEF_ESC_CHAR = 8'h2B;
	localparam logic [15:0] DEF_BIT_PERIOD = 16'h1047;
	localparam logic [3:0] DEF_FRAME_BITS = 4'hA;
	// ------------------------------------------------------------
	// Frame type byte of a received radio data frame
	// ------------------------------------------------------------
	localparam logic [7:0] FT_RX_DATA = 8'h90;

	typedef struct packed {
		logic [7:0] idle_packetize_chars;
		logic [15:0] silence_guard_time;
		logic [7:0] escape_sequence_char;
		logic [15:0] bit_period;
		logic [3:0] frame_bits;
	} srp_cfg_s;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} srp_byte_s;

	typedef enum {ESC_IDLE, ESC_CHARS, ESC_POST, ESC_FLUSH, ESC_DRAIN, ESC_CMD} srp_esc_e;
	typedef enum {H_IDLE, H_CODE, H_ADDR_HI, H_ADDR_LO, H_PAYLOAD} srp_host_e;
endpackage

/* File: sim/srp_host_model.sv */
// Host model: serial byte source and stalling sink of bytes sent to the host.
`timescale 1ns/100ps
module srp_host_model import srp_pkg::*; (
	input wire logic clk,
	output logic din_pin,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic host_valid,
	input wire srp_byte_s host_byte,
	output logic host_ready
);
	srp_byte_s got[$];
	int cyc = 0;
	initial begin
		din_pin = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		host_ready = 1'b0;
	end
	// Ready is low two cycles in three so the held output is exercised.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		host_ready <= (cyc % 3 == 0);
		if (host_valid && host_ready)
			got.push_back(host_byte);
	end
	// The line goes low ahead of the byte, as a start bit would, so the idle timer has
	// restarted before the byte is queued; data is inverted once released.
	task automatic send(input logic [7:0] b, input int gap);
		@(posedge clk);
		din_pin <= 1'b0;
		repeat (3) @(posedge clk);
		din_pin <= 1'b1;
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		repeat (gap) @(posedge clk);
	endtask
endmodule

/* File: sim/srp_packetizer_bench.sv */
// Self-checking bench of the serial RF packetizer.
`timescale 1ns/100ps
module srp_packetizer_bench import srp_pkg::*;;
	logic clk, reset, din_pin, rx_valid, spi_port_select, framed_mode_select, cfg_load, cmd_exit;
	logic serial_rx_ready, command_mode, cmd_valid, frame_in_valid, tx_valid, tx_ready;
	logic rf_valid, rf_ack, ev_valid, ev_ack, host_valid, host_ready;
	logic [7:0] rx_data, cmd_data, frame_in_data, ev_type, ev_code;
	logic [15:0] rf_src_addr;
	srp_cfg_s cfg_in, cfg_active;
	srp_byte_s tx_byte, rf_byte, host_byte;
	srp_byte_s txq[$];
	int n_mismatch = 0, n_tests = 0, cyc = 0, c0, i;
	typedef struct {logic fr; logic spi; logic [7:0] d; logic ex;} srp_row_s;
	srp_row_s rows[4] = '{'{1, 0, 8'hA5, 1}, '{0, 1, 8'h5A, 1}, '{1, 1, 8'h3C, 1}, '{0, 0, 8'hC3, 0}};
	logic [7:0] exp_host[9] = '{8'hB1, 8'hB2, 8'h90, 8'h12, 8'h34, 8'hB1, 8'hB2, 8'h8A, 8'h02};

	srp_packetizer #(.GUARD_TICK_CYCLES(10)) u_dut (.*);
	srp_host_model u_host (.*);

	always #12.5 clk = ~clk;
	// Radio side accepts three bytes in four.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tx_ready <= (cyc % 4 != 1);
		if (tx_valid && tx_ready)
			txq.push_back(tx_byte);
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic bit cond(input int w, input int n);
		case (w)
			0: return tx_valid === 1'b1;
			1: return command_mode === 1'b1;
			2: return rf_ack === 1'b1;
			3: return ev_ack === 1'b1;
			4: return txq.size() >= n;
			default: return u_host.got.size() >= n;
		endcase
	endfunction
	task automatic wait_on(input int w, input int n, input int lim);
		int k;
		k = 0;
		while (!cond(w, n) && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (!cond(w, n)) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t wait %h limit %h", $time, w, lim);
			final_report();
		end
	endtask
	// Config only loads while framed or in command mode, so framing is raised around the load.
	task automatic load_cfg(input logic [7:0] idle);
		@(posedge clk);
		framed_mode_select <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b1;
		cfg_in <= '{idle, 16'h0005, 8'h2B, 16'h000A, 4'hA};
		@(posedge clk);
		cfg_load <= 1'b0;
		framed_mode_select <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic rf_send;
		@(posedge clk);
		rf_valid <= 1'b1;
		rf_byte <= '{8'hB1, 1'b0};
		for (int j = 0; j < 2; j++) begin
			#1;
			wait_on(2, 0, 300);
			if (j == 0)
				rf_byte <= '{8'hB2, 1'b1};
			else
				rf_valid <= 1'b0;
		end
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{clk, reset} = 2'b01;
		{spi_port_select, framed_mode_select, cfg_load, cmd_exit} = 4'h0;
		{rf_valid, ev_valid, ev_type, ev_code} = 18'h0_0000;
		rf_byte = '0;
		rf_src_addr = 16'h1234;
		cfg_in = '0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		chk(cfg_active, {8'h03, 16'h03E8, 8'h2B, DEF_BIT_PERIOD, DEF_FRAME_BITS});
		chk(serial_rx_ready, 1);
		$display("reset test done");
		load_cfg(8'h03);
		foreach (rows[r]) begin
			@(posedge clk);
			framed_mode_select <= rows[r].fr;
			spi_port_select <= rows[r].spi;
			u_host.send(rows[r].d, 0);
			#1;
			chk(frame_in_valid, rows[r].ex);
			chk(frame_in_valid ? frame_in_data : 8'h00, rows[r].ex ? rows[r].d : 8'h00);
		end
		wait_on(4, 1, 4200);
		chk(txq[0], {8'hC3, 1'b1});
		$display("routing test done");
		for (i = 0; i < 2; i++) begin
			load_cfg(i ? 8'h32 : 8'h03);
			txq.delete();
			u_host.send(8'h11, 0);
			c0 = cyc;
			wait_on(0, 0, 6000);
			chk((cyc - c0) inside {[4000 + 1000 * i : 4012 + 1000 * i]}, 1);
			wait_on(4, 1, 20);
		end
		$display("idle test done");
		load_cfg(8'h00);
		txq.delete();
		u_host.send(8'h77, 0);
		wait_on(0, 0, 12);
		wait_on(4, 1, 12);
		chk(txq[0], {8'h77, 1'b1});
		$display("immediate test done");
		load_cfg(8'h03);
		txq.delete();
		for (i = 0; i < 33; i++)
			u_host.send(8'(i), 10);
		wait_on(4, 32, 100);
		chk({txq[30].last, txq[31]}, {1'b0, 8'h1F, 1'b1});
		wait_on(4, 33, 4200);
		chk(txq[32], {8'h20, 1'b1});
		$display("full packet test done");
		txq.delete();
		u_host.send(8'hA1, 2);
		u_host.send(8'hA2, 60);
		repeat (3) u_host.send(8'h2B, 12);
		wait_on(1, 0, 200);
		chk(txq.size() + tx_valid, 2);
		chk(txq[0], {8'hA1, 1'b0});
		u_host.send(8'h41, 0);
		#1;
		chk(cmd_valid ? cmd_data : 8'h00, 8'h41);
		cfg_load <= 1'b1;
		cfg_in.idle_packetize_chars <= 8'h07;
		@(posedge clk);
		cfg_load <= 1'b0;
		cmd_exit <= 1'b1;
		@(posedge clk);
		cmd_exit <= 1'b0;
		repeat (3) @(posedge clk);
		cfg_load <= 1'b1;
		cfg_in.idle_packetize_chars <= 8'h09;
		@(posedge clk);
		cfg_load <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({command_mode, cfg_active.idle_packetize_chars}, {1'b0, 8'h07});
		chk(txq.size(), 2);
		$display("escape test done");
		rf_send();
		framed_mode_select <= 1'b1;
		rf_send();
		@(posedge clk);
		ev_valid <= 1'b1;
		ev_type <= 8'h8A;
		ev_code <= 8'h02;
		#1;
		wait_on(3, 0, 300);
		ev_valid <= 1'b0;
		wait_on(5, 9, 300);
		foreach (exp_host[k])
			chk(u_host.got[k].data, exp_host[k]);
		chk({u_host.got[6].last, u_host.got[8].last}, 2'b11);
		$display("host test done");
		final_report();
	end
endmodule

/* File: sim/srp_packetizer_props.sv */
// Port-level assertions of the serial RF packetizer and their bind.
`timescale 1ns/100ps
module srp_packetizer_props import srp_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic spi_port_select,
	input wire logic framed_mode_select,
	input wire srp_cfg_s cfg_active,
	input wire logic command_mode,
	input wire logic cmd_valid,
	input wire logic frame_in_valid,
	input wire logic tx_valid,
	input wire srp_byte_s tx_byte,
	input wire logic tx_ready,
	input wire logic host_valid,
	input wire srp_byte_s host_byte,
	input wire logic host_ready
);
	logic trans;
	logic [5:0] n_tx;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	assign trans = !framed_mode_select && !spi_port_select;
	// Counts accepted radio bytes, so a packet that runs past its limit is caught.
	always_ff @(posedge clk) begin
		if (reset || (tx_valid && tx_ready && tx_byte.last))
			n_tx <= 6'h00;
		else if (tx_valid && tx_ready)
			n_tx <= n_tx + 6'h01;
	end
	a_tx_held: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("radio byte changed while stalled");
	a_host_held: assert property (
		host_valid && !host_ready |=> host_valid && $stable(host_byte))
		else $error("host byte changed while stalled");
	a_packet_cap: assert property (tx_valid && n_tx == 6'h1F |-> tx_byte.last)
		else $error("packet longer than limit");
	a_cmd_echo: assert property (
		rx_valid && command_mode && trans |=> cmd_valid && !frame_in_valid)
		else $error("command byte not passed on");
	a_framed_in: assert property (
		rx_valid && !trans && !command_mode |=> frame_in_valid && !cmd_valid)
		else $error("framed byte not passed on");
	a_transp_raw: assert property (rx_valid && trans |=> !frame_in_valid)
		else $error("frame output in transparent use");
	a_cmd_entry: assert property ($rose(command_mode) |-> $past(trans))
		else $error("command mode entered while framed");
	a_cfg_frozen: assert property ((trans && !command_mode) [*4] |-> $stable(cfg_active))
		else $error("configuration changed outside command mode");
	c_cmd_entry: cover property ($rose(command_mode));
	c_full_packet: cover property (tx_valid && tx_ready && n_tx == 6'h1F);
	c_host_end: cover property (host_valid && host_ready && host_byte.last);
endmodule

bind srp_packetizer srp_packetizer_props u_props (.*);
